// *** pmcc_divider.sv ***
// divider that forms the internal master clock enable from the source clock
`default_nettype none
module pmcc_divider (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       gate,
  input  wire logic [1:0] code,
  output logic            tick,
  output logic [1:0]      count
);
  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } pmcc_div_s;

  pmcc_div_s st;
  pmcc_div_s next_st;
  logic [1:0] limit;

  // terminal count per divider code, reserved code clears the count and gives no tick
  always_comb begin
    next_st = st;
    case (code)
      pmcc_pkg::DIV_BY1: limit = 2'h0;
      pmcc_pkg::DIV_BY2: limit = 2'h1;
      pmcc_pkg::DIV_BY3: limit = 2'h2;
      default:           limit = 2'h3;
    endcase
    next_st.tick = 1'b0;
    if (gate || code == pmcc_pkg::DIV_RSVD) begin
      next_st.cnt = 2'h0;
    end else if (st.cnt >= limit) begin
      next_st.cnt  = 2'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 2'h1;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick  = st.tick;
  assign count = st.cnt;
endmodule // pmcc_divider
`default_nettype wire

// *** pmcc_pkg.sv ***
// package of register offsets, field positions and reset values for power and master clock control
`default_nettype none
package pmcc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_MASTER_CLOCK  = 8'h07;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_POWER_CONTROL  = 8'h10;
  localparam logic [7:0] RST_MASTER_CLOCK   = 8'h04;
  // ==========================================================
  // power control fields
  localparam int BIT_ULP_SHUTDOWN  = 7;
  localparam int BIT_PARTIAL_PDN   = 6;
  localparam int BIT_REF_CLAMP     = 5;
  localparam int BIT_THERMAL_OFF   = 4;
  localparam logic [7:0] MASK_POWER_CONTROL = 8'hf0;
  // ==========================================================
  // master clock control fields
  localparam int BIT_TREE_GATE     = 7;
  localparam int BIT_CLK_SCALE     = 6;
  localparam int BIT_DIGITAL_MIC_CLOCK_DRIVE    = 5;
  localparam int BIT_DIV_HI        = 3;
  localparam int BIT_DIV_LO        = 2;
  localparam int BIT_SYNC_ENABLE   = 1;
  localparam logic [7:0] MASK_MASTER_CLOCK = 8'hee;
  // ==========================================================
  // divider codes
  localparam logic [1:0] DIV_BY1  = 2'h0;
  localparam logic [1:0] DIV_BY2  = 2'h1;
  localparam logic [1:0] DIV_BY3  = 2'h2;
  localparam logic [1:0] DIV_RSVD = 2'h3;
  // ==========================================================
  // sync sequence length in clock cycles
  localparam logic [3:0] SYNC_CYCLES = 4'h8;
endpackage
`default_nettype wire

// *** pmcc_top.sv ***
// power and master clock control registers with their derived controls
`default_nettype none
module pmcc_top (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic [7:0]      rdata,
  input  wire logic [3:0] block_pdn,
  input  wire logic       serial_port_rate,
  input  wire logic       sample_rate_ratio,
  output logic            adc_power_down,
  output logic            ref_power_down,
  output logic            keep_alive,
  output logic            ref_cap_clamp,
  output logic            thermal_sense_off,
  output logic            clock_tree_run,
  output logic            mclk_int_tick,
  output logic [2:0]      scale_ratio,
  output logic            digital_mic_clock_drive,
  output logic            sync_start,
  output logic            sync_busy
);
  // ==========================================================
  // reset release
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] power_control;
    logic [7:0] master_clock_control;
    logic [7:0] rdata;
    logic [3:0] sync_cnt;
    logic       sync_start;
  } pmcc_state_s;

  pmcc_state_s st;
  pmcc_state_s next_st;
  logic        sync_rise;

  // ==========================================================
  // address decode shared by the write path and the checks
  function automatic logic wr_hit(input logic stb, input logic [7:0] a, input logic [7:0] target);
    return stb && (a == target);
  endfunction

  // register writes, readback and sync sequencing
  always_comb begin
    next_st = st;
    next_st.sync_start = 1'b0;
    sync_rise = 1'b0;
    if (wr_hit(wr_stb, addr, pmcc_pkg::ADDR_POWER_CONTROL)) begin
      next_st.power_control = wdata & pmcc_pkg::MASK_POWER_CONTROL;
    end
    if (wr_hit(wr_stb, addr, pmcc_pkg::ADDR_MASTER_CLOCK)) begin
      next_st.master_clock_control = wdata & pmcc_pkg::MASK_MASTER_CLOCK;
      sync_rise = wdata[pmcc_pkg::BIT_SYNC_ENABLE]
                  && !st.master_clock_control[pmcc_pkg::BIT_SYNC_ENABLE];
    end
    if (sync_rise) begin
      next_st.sync_start = 1'b1;
      next_st.sync_cnt   = pmcc_pkg::SYNC_CYCLES;
    end else if (st.sync_cnt != 4'h0) begin
      next_st.sync_cnt = st.sync_cnt - 4'h1;
    end
    if (rd_stb) begin
      case (addr)
        pmcc_pkg::ADDR_POWER_CONTROL: next_st.rdata = st.power_control;
        pmcc_pkg::ADDR_MASTER_CLOCK:  next_st.rdata = st.master_clock_control;
        default:                      next_st.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.power_control        <= pmcc_pkg::RST_POWER_CONTROL;
      st.master_clock_control <= pmcc_pkg::RST_MASTER_CLOCK;
      st.rdata                <= 8'h00;
      st.sync_cnt             <= 4'h0;
      st.sync_start           <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // derived power controls
  logic ulp;
  logic lp;
  assign ulp = st.power_control[pmcc_pkg::BIT_ULP_SHUTDOWN];
  assign lp  = st.power_control[pmcc_pkg::BIT_PARTIAL_PDN];
  assign adc_power_down    = ulp || lp || (&block_pdn);
  assign ref_power_down    = ulp || lp;
  assign keep_alive        = lp && !ulp;
  assign ref_cap_clamp     = st.power_control[pmcc_pkg::BIT_REF_CLAMP];
  assign thermal_sense_off = st.power_control[pmcc_pkg::BIT_THERMAL_OFF];

  // ==========================================================
  // derived clock controls
  logic       tree_gate;
  logic [1:0] div_code;
  assign tree_gate = st.master_clock_control[pmcc_pkg::BIT_TREE_GATE];
  assign div_code  = st.master_clock_control[pmcc_pkg::BIT_DIV_HI:pmcc_pkg::BIT_DIV_LO];
  assign clock_tree_run = !tree_gate;
  assign digital_mic_clock_drive = st.master_clock_control[pmcc_pkg::BIT_DIGITAL_MIC_CLOCK_DRIVE];
  // ratio 1 when scaling off, else 2 or 4 from the rate settings
  assign scale_ratio = !st.master_clock_control[pmcc_pkg::BIT_CLK_SCALE] ? 3'h1
                     : (serial_port_rate && sample_rate_ratio) ? 3'h4 : 3'h2;
  assign rdata      = st.rdata;
  assign sync_start = st.sync_start;
  assign sync_busy  = st.sync_cnt != 4'h0;

  // internal master clock divider
  pmcc_divider u_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .gate    (tree_gate),
    .code    (div_code),
    .tick    (mclk_int_tick),
    .count   ()
  );

  // ==========================================================
  // assertions
  a_ulp_override:  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ulp |-> (!keep_alive && adc_power_down && ref_power_down)) else $error("shutdown not overriding");
  a_ulp_all_down:  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_stb && addr == pmcc_pkg::ADDR_POWER_CONTROL && wdata[7]) |=> ref_power_down)
    else $error("shutdown write ignored");
  a_lp_alive:      assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_stb && addr == pmcc_pkg::ADDR_POWER_CONTROL && wdata[7:6] == 2'h1) |=> keep_alive)
    else $error("partial power-down lost");
  a_clamp_follow:  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_stb && addr == pmcc_pkg::ADDR_POWER_CONTROL) |=> ref_cap_clamp == $past(wdata[5]))
    else $error("clamp mismatch");
  a_thermal_rst:   assert property (@(posedge ref_clk) $rose(rst_n) |-> thermal_sense_off)
    else $error("thermal sense not off at reset");
  a_tree_gate:     assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clock_tree_run |=> !mclk_int_tick) else $error("tick while gated");
  a_scale_off:     assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st.master_clock_control[6] |-> scale_ratio == 3'h1) else $error("ratio not one");
  a_digital_mic_clock_drive:    assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_stb && addr == pmcc_pkg::ADDR_MASTER_CLOCK) |=> digital_mic_clock_drive == $past(wdata[5]))
    else $error("drive mismatch");
  a_div_by3:       assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clock_tree_run && div_code == pmcc_pkg::DIV_BY3 && $stable(div_code) && mclk_int_tick)
    |=> !mclk_int_tick [*2]) else $error("divide by three wrong");
  a_sync_start:    assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_start |-> !$past(st.master_clock_control[1]) && st.master_clock_control[1])
    else $error("sync without rising edge");
  a_rsvd_zero:     assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_stb && addr == pmcc_pkg::ADDR_POWER_CONTROL) |=> rdata[3:0] == 4'h0)
    else $error("reserved bits nonzero");
  // power path: writes reach the derived controls one cycle later
  a_thermal_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_hit(wr_stb, addr, pmcc_pkg::ADDR_POWER_CONTROL) |=> thermal_sense_off == $past(wdata[4]))
    else $error("thermal sense mismatch");
  a_pdn_release:    assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_hit(wr_stb, addr, pmcc_pkg::ADDR_POWER_CONTROL) && wdata[7:6] == 2'h0)
    |=> (!ref_power_down && !keep_alive)) else $error("power-down not released");
  // clock path: gate, scaling and divider
  a_tree_follow:    assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_hit(wr_stb, addr, pmcc_pkg::ADDR_MASTER_CLOCK) |=> clock_tree_run == !$past(wdata[7]))
    else $error("clock tree mismatch");
  a_scale_on:       assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_hit(wr_stb, addr, pmcc_pkg::ADDR_MASTER_CLOCK) && wdata[6]) |=> scale_ratio inside {3'h2, 3'h4})
    else $error("ratio not two or four");
  a_div_by2:        assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clock_tree_run && div_code == pmcc_pkg::DIV_BY2 && $stable(div_code) && mclk_int_tick)
    |=> !mclk_int_tick) else $error("divide by two wrong");
  a_div_rsvd:       assert property (@(posedge ref_clk) disable iff (!rst_n)
    div_code == pmcc_pkg::DIV_RSVD |=> !mclk_int_tick) else $error("tick on reserved code");
  // sync sequence: no start without a raising write, fixed busy length; then master clock reserved readback bits
  a_sync_quiet:     assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(wr_hit(wr_stb, addr, pmcc_pkg::ADDR_MASTER_CLOCK) && wdata[1]) |=> !sync_start)
    else $error("sync start without write");
  a_busy_hold:      assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_start |-> sync_busy [*8]) else $error("sync busy too short");
  a_busy_end:       assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(sync_busy) |-> $past(sync_start, 8)) else $error("sync busy too long");
  a_mclk_rsvd:      assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_stb && addr == pmcc_pkg::ADDR_MASTER_CLOCK) |=> (rdata[4] == 1'b0 && rdata[0] == 1'b0))
    else $error("reserved clock bits nonzero");
  // ==========================================================
  // coverage of the main scenarios
  c_sync_run:  cover property (@(posedge ref_clk) disable iff (!rst_n) sync_start ##1 sync_busy);
  c_ulp_set:   cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(ulp));
  c_gated:     cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(clock_tree_run));
  c_scale_4:   cover property (@(posedge ref_clk) disable iff (!rst_n) scale_ratio == 3'h4);
  c_div_by3:   cover property (@(posedge ref_clk) disable iff (!rst_n) div_code == pmcc_pkg::DIV_BY3 && mclk_int_tick);
endmodule // pmcc_top
`default_nettype wire

// *** tb_top.sv ***
// self-checking testbench for the power and master clock control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // stimulus and observed signals
  logic       ref_clk, nrst, wr_stb, rd_stb, spr, sfr, sst;
  logic       adc_pd, ref_pd, keep, clamp, therm, run, tick, drive, start, busy;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] block_pdn;
  logic [2:0] ratio;
  int         fail_count, check_count, n;
  // row: power write/readback, clock write/readback, inputs, expected outputs
  typedef struct {logic [7:0] pw, pe, mc, me; logic [3:0] pdn; logic sr, fr; logic [9:0] o;} pmcc_row_s;
  pmcc_row_s rows [6] = '{
    '{8'h80, 8'h80, 8'h84, 8'h84, 4'h0, 1'b0, 1'b0, 10'h301},
    '{8'hc0, 8'hc0, 8'hc4, 8'hc4, 4'h0, 1'b1, 1'b1, 10'h304},
    '{8'h40, 8'h40, 8'h44, 8'h44, 4'h0, 1'b1, 1'b0, 10'h392},
    '{8'h00, 8'h00, 8'h24, 8'h24, 4'hf, 1'b0, 1'b0, 10'h219},
    '{8'h1f, 8'h10, 8'h15, 8'h04, 4'h7, 1'b1, 1'b1, 10'h031},
    '{8'ha0, 8'ha0, 8'ha4, 8'ha4, 4'h0, 1'b0, 1'b0, 10'h349}};
  int         tick_exp [4] = '{12, 6, 4, 0};
  // ==========================================================
  // device under test
  pmcc_top dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .block_pdn(block_pdn), .serial_port_rate(spr),
    .sample_rate_ratio(sfr), .adc_power_down(adc_pd), .ref_power_down(ref_pd), .keep_alive(keep),
    .ref_cap_clamp(clamp), .thermal_sense_off(therm), .clock_tree_run(run), .mclk_int_tick(tick),
    .scale_ratio(ratio), .digital_mic_clock_drive(drive), .sync_start(start), .sync_busy(busy));
  // clock of 10 ns period
  always #5 ref_clk = ~ref_clk;
  // ==========================================================
  // compare, bus and counting tasks
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1 sst = start;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 chk("rdata", {2'h0, e}, {2'h0, rdata});
  endtask
  // counts divided clock pulses over twelve cycles after settling
  task automatic ticks(input int e);
    int c;
    c = 0;
    repeat (3) @(posedge ref_clk);
    repeat (12) begin
      @(posedge ref_clk);
      #1 c += (tick === 1'b1);
    end
    chk("tick count", 10'(e), 10'(c));
  endtask
  task automatic busy_len(input int e);
    n = 0;
    repeat (10) begin
      n += (busy === 1'b1);
      @(posedge ref_clk);
      #1;
    end
    chk("sync busy cycles", 10'(e), 10'(n));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog against a hung run
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    ref_clk = 1'b0; nrst = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h00; wdata = 8'h00;
    block_pdn = 4'h0; spr = 1'b0; sfr = 1'b0; fail_count = 0; check_count = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk("reset outputs", 10'h030, {4'h0, therm, run, drive, clamp, start, busy});
    rd(8'h06, 8'h10);
    rd(8'h07, 8'h04);
    rd(8'h05, 8'h00);
    ticks(6);
    wr(8'h06, 8'h80);
    wr(8'h07, 8'h84);
    ticks(0);
    // each divider code changed while gated, then ungated
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, 8'h80 | 8'(i << 2));
      wr(8'h07, 8'(i << 2));
      ticks(tick_exp[i]);
    end
    wr(8'h07, 8'h8c);
    wr(8'h07, 8'h84);
    // table of power and clock settings
    foreach (rows[i]) begin
      @(posedge ref_clk);
      block_pdn <= rows[i].pdn;
      spr       <= rows[i].sr;
      sfr       <= rows[i].fr;
      wr(8'h06, rows[i].pw);
      wr(8'h07, rows[i].mc);
      chk("outputs", rows[i].o, {adc_pd, ref_pd, keep, clamp, therm, run, drive, ratio});
      rd(8'h06, rows[i].pe);
      rd(8'h07, rows[i].me);
    end
    // sync start on a rising write only, rerun after clearing
    wr(8'h07, 8'ha6);
    chk("sync start", 10'h001, {9'h0, sst});
    busy_len(8);
    wr(8'h07, 8'ha6);
    chk("sync repeat", 10'h000, {9'h0, sst | busy});
    wr(8'h07, 8'ha4);
    chk("sync clear", 10'h000, {9'h0, sst | busy});
    wr(8'h07, 8'ha6);
    chk("sync rerun", 10'h001, {9'h0, sst});
    // reset in mid-run, while the sync sequence is busy
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk("mid-run reset", 10'h030, {4'h0, therm, run, drive, clamp, start, busy});
    rd(8'h06, 8'h10);
    rd(8'h07, 8'h04);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
